/* File: logic/crc_byte_engine.v */
// Purpose: 16-bit checksum unit folding a byte stream, with indirect result read
// Assumes: all inputs come from logic on CLK_I, so none is synchronised
// Notes: one shift step per cycle; a byte takes nine cycles from take to done
//   init aborts a byte in flight; bytes still buffered run after it
//
// Function
// - checksum uses a 16-bit polynomial picked from the supported set
// - core writes 8-bit bytes to the input port; each one is folded in
// - internal 16-bit result register updated after every processed byte
// - pointer picks which result byte the data port returns on a read
// - separate bit-reversal register returns written value mirrored
// - each byte is first xored into the upper bits of the checksum
// - before first byte checksum equals start value, zeros or ones
// - top bit one: shift then xor with selected polynomial
// - top bit zero: shift only
// - conditional shift step runs eight times per byte
`timescale 1ns/10ps
`include "crc_defines.vh"
module crc_byte_engine (
  input wire CLK_I,
  input wire RST_N_I,
  input wire [`BYTE_MSB:0] CHECKSUM_INPUT_PORT_I,
  input wire CHECKSUM_INPUT_VALID_I,
  output wire CHECKSUM_INPUT_READY_O,
  input wire POLY_SEL_I,
  input wire START_ONES_I,
  input wire INIT_I,
  input wire RESULT_BYTE_POINTER_I,
  input wire RESULT_RD_I,
  output reg [`BYTE_MSB:0] RESULT_DATA_PORT_O,
  output reg RESULT_RD_VALID_O,
  input wire REV_WR_I,
  input wire [`BYTE_MSB:0] REV_DATA_I,
  output reg [`BYTE_MSB:0] REV_DATA_O,
  output reg [`CRC_MSB:0] RESULT_O,
  output reg BUSY_O,
  output reg BYTE_DONE_O
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  reg state_q;
  reg state_d;
  reg [`CRC_MSB:0] crc_q;
  reg [`CRC_MSB:0] crc_d;
  reg [3:0] step_q;
  reg [3:0] step_d;
  reg [`CRC_MSB:0] poly_q;
  reg done_d;
  wire [`BYTE_MSB:0] fifo_data;
  wire fifo_valid;
  wire fifo_take;

  // one conditional shift-and-reduce step
  function [`CRC_MSB:0] crc_step;
    input [`CRC_MSB:0] cur;
    input [`CRC_MSB:0] poly;
    begin
      if (cur[`CRC_MSB]) begin
        crc_step = {cur[`CRC_MSB-1:0], 1'b0} ^ poly;
      end else begin
        crc_step = {cur[`CRC_MSB-1:0], 1'b0};
      end
    end
  endfunction

  // mirror a byte end to end
  function [`BYTE_MSB:0] bit_mirror;
    input [`BYTE_MSB:0] v;
    integer i;
    begin
      bit_mirror = `BYTE_ZERO;
      for (i = 0; i < `BYTE_W; i = i + 1) begin
        bit_mirror[i] = v[`BYTE_MSB - i];
      end
    end
  endfunction

  // start value loaded by the init command, used on both init paths
  function [`CRC_MSB:0] start_value;
    input ones;
    begin
      if (ones) begin
        start_value = `START_ONES;
      end else begin
        start_value = `START_ZEROS;
      end
    end
  endfunction

  // polynomial picked by the select input
  function [`CRC_MSB:0] poly_value;
    input sel;
    begin
      if (sel) begin
        poly_value = `POLY_SEL1;
      end else begin
        poly_value = `POLY_SEL0;
      end
    end
  endfunction

  // buffer absorbs bytes while a previous one is still shifting
  crc_byte_fifo u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_data_i(CHECKSUM_INPUT_PORT_I),
    .in_valid_i(CHECKSUM_INPUT_VALID_I),
    .in_ready_o(CHECKSUM_INPUT_READY_O),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take)
  );

  // no byte is taken in an init cycle, so the start value is in place first
  assign fifo_take = (state_q == ST_IDLE) && !INIT_I && fifo_valid;

  // engine sequencing
  always @* begin
    state_d = state_q;
    crc_d = crc_q;
    step_d = step_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // init wins over a waiting byte
        if (INIT_I) begin
          crc_d = start_value(START_ONES_I);
        end else if (fifo_take) begin
          crc_d = crc_q ^ {fifo_data, `BYTE_ZERO};
          step_d = `STEP_CNT_ZERO;
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (INIT_I) begin
          // init aborts a byte in flight; its partial result is lost
          crc_d = start_value(START_ONES_I);
          state_d = ST_IDLE;
        end else begin
          crc_d = crc_step(crc_q, poly_q);
          step_d = step_q + `STEP_ONE;
          if (step_q == (`STEPS_PER_BYTE - `STEP_ONE)) begin
            state_d = ST_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer flops
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      crc_q <= `START_ZEROS;
      step_q <= `STEP_CNT_ZERO;
    end else begin
      state_q <= state_d;
      crc_q <= crc_d;
      step_q <= step_d;
    end
  end

  // polynomial latched only between bytes, so a byte never mixes two
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      poly_q <= `POLY_SEL0;
    end else if (state_d == ST_IDLE) begin
      poly_q <= poly_value(POLY_SEL_I);
    end
  end

  // visible result only moves on whole bytes or init, never mid-shift
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RESULT_O <= `START_ZEROS;
    end else if (done_d || INIT_I) begin
      RESULT_O <= crc_d;
    end
  end

  // status registered from next-state values plus current buffer occupancy for BUSY_O, so the state terms line up with the sequencer flops
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUSY_O <= 1'b0;
      BYTE_DONE_O <= 1'b0;
    end else begin
      BUSY_O <= (state_d == ST_SHIFT) || fifo_valid;
      BYTE_DONE_O <= done_d;
    end
  end

  // indirect result read; pointer high selects upper byte of last result
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RESULT_DATA_PORT_O <= `BYTE_ZERO;
      RESULT_RD_VALID_O <= 1'b0;
    end else begin
      RESULT_RD_VALID_O <= RESULT_RD_I;
      if (RESULT_RD_I) begin
        RESULT_DATA_PORT_O <= RESULT_BYTE_POINTER_I ?
          RESULT_O[`CRC_MSB:`BYTE_W] : RESULT_O[`BYTE_MSB:0];
      end
    end
  end

  // bit-reversal register, independent of the checksum path
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REV_DATA_O <= `BYTE_ZERO;
    end else if (REV_WR_I) begin
      REV_DATA_O <= bit_mirror(REV_DATA_I);
    end
  end
endmodule // crc_byte_engine

/* File: logic/crc_defines.vh */
// Purpose: shared constants of the checksum unit
// Assumes: included by its bare name
// Notes: polynomial values are neutral defaults and may be changed
`ifndef CRC_DEFINES_VH
`define CRC_DEFINES_VH
`define CRC_W 16
`define CRC_MSB 15
`define BYTE_W 8
`define BYTE_MSB 7
`define STEPS_PER_BYTE 4'h8
`define STEP_CNT_ZERO 4'h0
`define STEP_ONE 4'h1
`define START_ZEROS 16'h0000
`define START_ONES 16'hFFFF
`define POLY_SEL0 16'h1021
`define POLY_SEL1 16'h8005
`define BYTE_ZERO 8'h00
`define FIFO_DEPTH 2'h2
`define FIFO_EMPTY 2'h0
`define FIFO_ONE 2'h1
`endif

/* File: logic/crc_byte_fifo.v */
// Purpose: two-entry byte buffer in front of the checksum engine
// Assumes: single clock, asynchronous active-low reset
// Notes: ready comes from a flop so the producer sees no combinational path
`timescale 1ns/10ps
`include "crc_defines.vh"
module crc_byte_fifo (
  input wire clk_i,
  input wire rst_n_i,
  input wire [`BYTE_MSB:0] in_data_i,
  input wire in_valid_i,
  output reg in_ready_o,
  output wire [`BYTE_MSB:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [`BYTE_MSB:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  reg [1:0] count_d;
  wire push;
  wire pop;

  // handshakes on both sides
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (count_q != `FIFO_EMPTY);
  assign out_data_o = mem_q[rd_ptr_q];

  // occupancy after this cycle
  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + `FIFO_ONE;
    end else if (pop && !push) begin
      count_d = count_q - `FIFO_ONE;
    end
  end

  // pointers, count and registered ready
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= `FIFO_EMPTY;
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_d;
      in_ready_o <= (count_d != `FIFO_DEPTH); // stalls producer when full
    end
  end

  // storage needs no reset, read only when counted valid
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end
endmodule // crc_byte_fifo

/* File: dv/crc_monitor.sv */
// Purpose: port checks for the checksum unit
// Assumes: one clock, async active-low reset
// Notes: a read returns RESULT_O as it stood at the taking edge
`timescale 1ns/10ps
module crc_monitor (
  input wire CLK_I,
  input wire RST_N_I,
  input wire INIT_I,
  input wire START_ONES_I,
  input wire RESULT_BYTE_POINTER_I,
  input wire RESULT_RD_I,
  input wire [7:0] RESULT_DATA_PORT_O,
  input wire RESULT_RD_VALID_O,
  input wire REV_WR_I,
  input wire [7:0] REV_DATA_I,
  input wire [7:0] REV_DATA_O,
  input wire [15:0] RESULT_O,
  input wire BUSY_O,
  input wire BYTE_DONE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // reference mirror kept apart from the design's own function
  function automatic logic [7:0] f_mirror(input logic [7:0] v);
    for (int i = 0; i < 8; i++) f_mirror[i] = v[7 - i];
  endfunction
  // read port, mirror and init answers
  property p_rdv; RESULT_RD_I |=> RESULT_RD_VALID_O; endproperty
  a_rdv: assert property (p_rdv) else $error("read valid missing");
  property p_rdd; RESULT_RD_I |=> RESULT_DATA_PORT_O == ($past(RESULT_BYTE_POINTER_I) ?
    $past(RESULT_O[15:8]) : $past(RESULT_O[7:0])); endproperty
  a_rdd: assert property (p_rdd) else $error("read byte wrong");
  property p_rev; REV_WR_I |=> REV_DATA_O == f_mirror($past(REV_DATA_I)); endproperty
  a_rev: assert property (p_rev) else $error("mirror wrong");
  property p_init; INIT_I |=> RESULT_O == {16{$past(START_ONES_I)}}; endproperty
  a_init: assert property (p_init) else $error("start value wrong");
  property p_initq; INIT_I |=> !BYTE_DONE_O [*8]; endproperty
  a_initq: assert property (p_initq) else $error("byte done too soon after init");
  // result only moves on done or init; eight steps space the dones
  property p_done; $changed(RESULT_O) && !$past(INIT_I) |-> BYTE_DONE_O; endproperty
  a_done: assert property (p_done) else $error("result moved without done");
  property p_gap; BYTE_DONE_O |=> !BYTE_DONE_O [*8]; endproperty
  a_gap: assert property (p_gap) else $error("dones too close");
  property p_busy; BYTE_DONE_O |-> $past(BUSY_O); endproperty
  a_busy: assert property (p_busy) else $error("done without busy");
endmodule // crc_monitor

bind crc_byte_engine crc_monitor u_mon (.CLK_I, .RST_N_I, .INIT_I, .START_ONES_I,
  .RESULT_BYTE_POINTER_I, .RESULT_RD_I, .RESULT_DATA_PORT_O, .RESULT_RD_VALID_O,
  .REV_WR_I, .REV_DATA_I, .REV_DATA_O, .RESULT_O, .BUSY_O, .BYTE_DONE_O);

/* File: dv/crc_core_model.sv */
// Purpose: byte producer standing in for the core
// Assumes: bench pushes bytes into q after reset
// Notes: wait_n adds idle cycles to act as a slow core
`timescale 1ns/10ps
module crc_core_model (
  input wire clk_i,
  input wire ready_i,
  output logic [7:0] data_o,
  output logic valid_o
);
  logic [7:0] q[$];
  int wait_n = 0;
  int cnt = 0;
  logic tk;
  initial valid_o = 0;
  initial data_o = 8'h5A;
  // hold offer until taken; released line shows inverse so no stale byte passes
  always @(posedge clk_i) begin
    tk = valid_o && ready_i;
    #1;
    if (tk) begin
      valid_o = 0;
      data_o = ~data_o;
      cnt = wait_n;
    end else if (cnt > 0) cnt--;
    else if (!valid_o && q.size() > 0) begin
      data_o = q.pop_front();
      valid_o = 1;
    end
  end
endmodule // crc_core_model

/* File: dv/crc_byte_engine_tb.sv */
// Purpose: self-checking bench of the checksum unit
// Assumes: inputs change 1 ns after the rising edge
// Notes: reference folds msb-first from the rules
`timescale 1ns/10ps
`include "crc_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module crc_byte_engine_tb;
  logic CLK_I = 0, RST_N_I = 0, POLY_SEL_I = 0, START_ONES_I = 0, INIT_I = 0;
  logic RESULT_BYTE_POINTER_I = 0, RESULT_RD_I = 0, REV_WR_I = 0, full;
  logic [7:0] REV_DATA_I = 8'h00, CHECKSUM_INPUT_PORT_I, RESULT_DATA_PORT_O, REV_DATA_O;
  logic CHECKSUM_INPUT_VALID_I, CHECKSUM_INPUT_READY_O, RESULT_RD_VALID_O, BUSY_O, BYTE_DONE_O;
  logic [15:0] RESULT_O, ecrc;
  int mismatches = 0, comparisons = 0;
  always #5 CLK_I = ~CLK_I;
  crc_byte_engine dut (.CLK_I, .RST_N_I, .CHECKSUM_INPUT_PORT_I, .CHECKSUM_INPUT_VALID_I,
    .CHECKSUM_INPUT_READY_O, .POLY_SEL_I, .START_ONES_I, .INIT_I, .RESULT_BYTE_POINTER_I,
    .RESULT_RD_I, .RESULT_DATA_PORT_O, .RESULT_RD_VALID_O, .REV_WR_I, .REV_DATA_I,
    .REV_DATA_O, .RESULT_O, .BUSY_O, .BYTE_DONE_O);
  crc_core_model u_core (.clk_i(CLK_I), .ready_i(CHECKSUM_INPUT_READY_O),
    .data_o(CHECKSUM_INPUT_PORT_I), .valid_o(CHECKSUM_INPUT_VALID_I));
  // reference: xor into top byte, then eight conditional shift steps
  function automatic logic [15:0] f_crc(logic [15:0] c, logic [7:0] b, logic [15:0] p);
    c ^= {b, 8'h00};
    repeat (8) c = c[15] ? ({c[14:0], 1'b0} ^ p) : {c[14:0], 1'b0};
    return c;
  endfunction
  task t_init(input logic so);
    @(posedge CLK_I); #1;
    START_ONES_I = so;
    INIT_I = 1;
    @(posedge CLK_I); #1;
    INIT_I = 0;
    ecrc = so ? `START_ONES : `START_ZEROS;
    `CHK(RESULT_O, ecrc)
  endtask
  // bounded wait for one finished byte, noting a full buffer
  task wait_done;
    int n;
    n = 0;
    do begin @(posedge CLK_I); #1; if (!CHECKSUM_INPUT_READY_O) full = 1; n++; end
    while (BYTE_DONE_O !== 1'b1 && n < 40);
    `CHK(BYTE_DONE_O, 1'b1)
  endtask
  task t_bytes(input logic s);
    logic [7:0] b[4];
    b = '{8'h31, 8'h80, 8'h00, 8'hFF};
    POLY_SEL_I = s;
    full = 0;
    t_init(1'b1);
    u_core.wait_n = s ? 5 : 0;
    foreach (b[i]) u_core.q.push_back(b[i] ^ {7'h00, s});
    foreach (b[i]) begin
      ecrc = f_crc(ecrc, b[i] ^ {7'h00, s}, s ? `POLY_SEL1 : `POLY_SEL0);
      wait_done;
      `CHK(RESULT_O, ecrc)
    end
    if (!s) `CHK(full, 1'b1)
    `CHK(BUSY_O, 1'b0)
  endtask
  // init in mid-shift drops that byte; the next byte folds from zero
  task t_abort;
    u_core.wait_n = 0;
    u_core.q.push_back(8'hA5);
    repeat (3) @(posedge CLK_I);
    #1;
    `CHK(BUSY_O, 1'b1)
    t_init(1'b0);
    u_core.q.push_back(8'h12);
    ecrc = f_crc(ecrc, 8'h12, `POLY_SEL0);
    wait_done;
    `CHK(RESULT_O, ecrc)
  endtask
  // back-to-back reads of both halves
  task t_read;
    @(posedge CLK_I); #1;
    RESULT_RD_I = 1;
    for (int p = 0; p < 2; p++) begin
      RESULT_BYTE_POINTER_I = p[0];
      @(posedge CLK_I); #1;
      `CHK(({RESULT_RD_VALID_O, RESULT_DATA_PORT_O}), ({1'b1, ecrc[8*p +: 8]}))
    end
    RESULT_RD_I = 0;
  endtask
  task t_rev(input logic [7:0] v, input logic [7:0] e);
    @(posedge CLK_I); #1;
    REV_WR_I = 1;
    REV_DATA_I = v;
    @(posedge CLK_I); #1;
    REV_WR_I = 0;
    `CHK(REV_DATA_O, e)
  endtask
  task final_report;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge CLK_I);
    #1 RST_N_I = 1;
    t_init(1'b0);
    t_abort;
    t_bytes(1'b0);
    t_read;
    t_bytes(1'b1);
    t_read;
    t_rev(8'h1E, 8'h78);
    t_rev(8'h01, 8'h80);
    final_report;
  end
endmodule // crc_byte_engine_tb
